// *** tw_pkg.sv ***
// Package of the two-wire bus master: register map, fields, reset values, link timing
// and the words that pass between the bus domain and the link domain.
// Assumes a 48 ns link clock and 32-bit AHB-Lite register access.
package tw_pkg;

    // =====================================================================
    // Register map.
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_CMD   = 8'h04;
    localparam logic [7:0] OFS_TXD   = 8'h08;
    localparam logic [7:0] OFS_RXD   = 8'h0c;
    localparam logic [7:0] OFS_STAT  = 8'h10;
    localparam logic [7:0] OFS_PRESC = 8'h14;

    // =====================================================================
    // Field positions.
    localparam int CTRL_EN    = 0;
    localparam int CTRL_DIS   = 1;
    localparam int CTRL_GO    = 2;
    localparam int CMD_RD     = 7;
    localparam int CMD_NB_LSB = 8;
    localparam int STAT_IDLE  = 0;
    localparam int STAT_NAK   = 1;
    localparam int STAT_ALERT = 2;

    // =====================================================================
    // Reset values and limits.
    localparam logic       EN_RST    = 1'b0;
    localparam logic       ALERT_RST = 1'b1;
    localparam logic [2:0] MAX_BYTES = 3'h4;

    // =====================================================================
    // Link timing.
    localparam int LINK_CLK_NS   = 48;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QUARTER_CYC   = SCL_PERIOD_NS / (4 * LINK_CLK_NS);
    localparam logic [7:0] PRESC_RST = 8'(QUARTER_CYC - 1);

    // =====================================================================
    // Crossing words and engine states.
    typedef struct packed {
        logic [6:0]  addr;
        logic        rd;
        logic [2:0]  nbytes;
        logic [31:0] txdata;
        logic [7:0]  presc;
    } tw_cmd_type;

    typedef struct packed {
        logic        nak;
        logic [31:0] rxdata;
    } tw_res_type;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_BYTE  = 5'h04,
        ST_ACK   = 5'h08,
        ST_STOP  = 5'h10
    } tw_state_type;

endpackage : tw_pkg

// *** tw_engine.sv ***
// Bit engine of the two-wire master, running on the link clock.
// Assumes synchronised inputs and a command word held stable around each request.
`timescale 1ns/1ps
module tw_engine (
    input  logic               link_clk,
    input  logic               rst_n,
    input  logic               req_lvl,
    input  logic               dis,
    input  tw_pkg::tw_cmd_type cmd,
    input  logic               scl_in,
    input  logic               sda_in,
    output logic               done_tgl,
    output tw_pkg::tw_res_type res,
    output logic               scl_oe_n,
    output logic               sda_oe_n
);

    // =====================================================================
    // State.
    tw_pkg::tw_state_type st_r, st_nxt;
    tw_pkg::tw_cmd_type   cmd_r, cmd_nxt;
    logic [1:0]  q_r, q_nxt;
    logic [7:0]  div_r, div_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic [2:0]  left_r, left_nxt;
    logic [1:0]  bidx_r, bidx_nxt;
    logic        aph_r, aph_nxt;
    logic        ack_r, ack_nxt;
    logic        nak_r, nak_nxt;
    logic [31:0] rx_r, rx_nxt;
    logic        done_r, done_nxt;
    logic        early_r, early_nxt;
    logic        seen_r, seen_nxt;
    logic        scl_r, scl_nxt;
    logic        sda_r, sda_nxt;
    logic        tick;
    logic        rxing;

    assign tick  = (div_r == 8'h00) && !(scl_r && !scl_in);
    assign rxing = cmd_r.rd && !aph_r;

    always_comb begin : eng_comb
        st_nxt = st_r; cmd_nxt = cmd_r; q_nxt = q_r; div_nxt = div_r;
        bit_nxt = bit_r; sh_nxt = sh_r; left_nxt = left_r; bidx_nxt = bidx_r;
        aph_nxt = aph_r; ack_nxt = ack_r; nak_nxt = nak_r; rx_nxt = rx_r;
        done_nxt = done_r; early_nxt = early_r; seen_nxt = seen_r;
        scl_nxt = scl_r; sda_nxt = sda_r;
        if (div_r != 8'h00) begin
            div_nxt = div_r - 8'h01;
        end else if (tick) begin
            div_nxt = cmd_r.presc;
        end
        if (tick) begin
            q_nxt = q_r + 2'h1;
        end
        case (st_r)
            tw_pkg::ST_IDLE: begin
                scl_nxt = 1'b1; sda_nxt = 1'b1; q_nxt = 2'h0; div_nxt = 8'h00;
                if (req_lvl != seen_r) begin
                    seen_nxt = req_lvl; cmd_nxt = cmd; nak_nxt = 1'b0;
                    early_nxt = 1'b0; rx_nxt = 32'h0; st_nxt = tw_pkg::ST_START;
                end
            end
            tw_pkg::ST_START: if (tick) begin
                case (q_r)
                    2'h0: begin scl_nxt = 1'b1; sda_nxt = 1'b1; end
                    2'h1: sda_nxt = 1'b0;
                    2'h2: scl_nxt = 1'b0;
                    default: begin
                        st_nxt = tw_pkg::ST_BYTE; sh_nxt = {cmd_r.addr, cmd_r.rd};
                        bit_nxt = 3'h7; aph_nxt = 1'b1;
                        left_nxt = cmd_r.nbytes; bidx_nxt = 2'h0;
                    end
                endcase
            end
            tw_pkg::ST_BYTE: if (tick) begin
                case (q_r)
                    2'h0: begin scl_nxt = 1'b0; sda_nxt = rxing | sh_r[7]; end
                    2'h1: scl_nxt = 1'b1;
                    2'h2: if (rxing) sh_nxt = {sh_r[6:0], sda_in};
                    default: begin
                        scl_nxt = 1'b0; bit_nxt = bit_r - 3'h1;
                        if (!rxing) sh_nxt = {sh_r[6:0], 1'b0};
                        if (bit_r == 3'h0) st_nxt = tw_pkg::ST_ACK;
                    end
                endcase
            end
            tw_pkg::ST_ACK: if (tick) begin
                case (q_r)
                    2'h0: sda_nxt = rxing ? (left_r == 3'h1) : 1'b1;
                    2'h1: scl_nxt = 1'b1;
                    2'h2: ack_nxt = sda_in;
                    default: begin
                        scl_nxt = 1'b0; bit_nxt = 3'h7;
                        if (rxing) begin
                            rx_nxt[{bidx_r, 3'h0} +: 8] = sh_r;
                            bidx_nxt = bidx_r + 2'h1; left_nxt = left_r - 3'h1;
                            st_nxt = (left_r == 3'h1) ? tw_pkg::ST_STOP : tw_pkg::ST_BYTE;
                        end else if (ack_r) begin
                            nak_nxt = 1'b1; st_nxt = tw_pkg::ST_STOP; // R09
                            if (left_r != 3'h0) begin
                                early_nxt = 1'b1; done_nxt = ~done_r; // R01
                            end
                        end else if (left_r == 3'h0) begin
                            st_nxt = tw_pkg::ST_STOP;
                        end else begin
                            st_nxt = tw_pkg::ST_BYTE; aph_nxt = 1'b0;
                            if (!cmd_r.rd) begin
                                sh_nxt = cmd_r.txdata[{bidx_r, 3'h0} +: 8];
                                bidx_nxt = bidx_r + 2'h1; left_nxt = left_r - 3'h1;
                            end
                        end
                    end
                endcase
            end
            tw_pkg::ST_STOP: if (tick) begin
                case (q_r)
                    2'h0: begin scl_nxt = 1'b0; sda_nxt = 1'b0; end
                    2'h1: scl_nxt = 1'b1; // R09
                    2'h2: sda_nxt = 1'b1; // R09
                    default: begin
                        if (!early_r) done_nxt = ~done_r;
                        st_nxt = tw_pkg::ST_IDLE;
                    end
                endcase
            end
            default: st_nxt = tw_pkg::ST_IDLE;
        endcase
        if (dis) begin
            st_nxt = tw_pkg::ST_IDLE; scl_nxt = 1'b1; sda_nxt = 1'b1; // R02
            seen_nxt = req_lvl;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= tw_pkg::ST_IDLE; cmd_r <= '0; q_r <= 2'h0; div_r <= 8'h00;
            bit_r <= 3'h0; sh_r <= 8'h00; left_r <= 3'h0; bidx_r <= 2'h0;
            aph_r <= 1'b0; ack_r <= 1'b0; nak_r <= 1'b0; rx_r <= 32'h0;
            done_r <= 1'b0; early_r <= 1'b0; seen_r <= 1'b0;
            scl_r <= 1'b1; sda_r <= 1'b1;
        end else begin
            st_r <= st_nxt; cmd_r <= cmd_nxt; q_r <= q_nxt; div_r <= div_nxt;
            bit_r <= bit_nxt; sh_r <= sh_nxt; left_r <= left_nxt; bidx_r <= bidx_nxt;
            aph_r <= aph_nxt; ack_r <= ack_nxt; nak_r <= nak_nxt; rx_r <= rx_nxt;
            done_r <= done_nxt; early_r <= early_nxt; seen_r <= seen_nxt;
            scl_r <= scl_nxt; sda_r <= sda_nxt;
        end
    end

    assign done_tgl   = done_r;
    assign res        = '{nak: nak_r, rxdata: rx_r};
    assign scl_oe_n   = scl_r;
    assign sda_oe_n   = sda_r;

    // =====================================================================
    // Checks.
    sequence s_nak_left;
        st_r == tw_pkg::ST_ACK && tick && q_r == 2'h3 && !rxing && ack_r && left_r != 3'h0;
    endsequence

    a_dis_release: assert property (@(posedge link_clk) disable iff (!rst_n) // R02
        dis |=> scl_r && sda_r && st_r == tw_pkg::ST_IDLE)
        else $error("lines not released after disable");

    a_nak_early_done: assert property (@(posedge link_clk) disable iff (!rst_n) // R01
        (s_nak_left and !dis) |=> (done_r != $past(done_r)) && st_r == tw_pkg::ST_STOP)
        else $error("no early done on nak");

    a_stop_rise: assert property (@(posedge link_clk) disable iff (!rst_n) // R09
        (st_r == tw_pkg::ST_STOP && $rose(sda_r)) |-> scl_r && $past(scl_r))
        else $error("stop edge without clock high");

endmodule : tw_engine

// *** tw_master.sv ***
// Two-wire bus master with an AHB-Lite register slave on hclk and its bit engine on link_clk.
// Assumes one AHB-Lite master doing single word transfers and open-drain pads outside.
`timescale 1ns/1ps
// =========================================================================
// Contract
// R01: NAK with bytes left sets idle at once.
// R02: Disable releases both lines immediately.
// R03: Software waits two clocks after idle.
// R04: Software should avoid disabling the master.
// R05: Alert input counts as asserted when high.
// R06: Alert unused when sharing pins with slave.
// R07: Alert status reads set after reset.
// R08: Software clears alert status before transfers.
// R09: NAK on write ends with a STOP.
module tw_master (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic [31:0] hrdata,
    output logic        hreadyout,
    output logic        hresp,
    input  logic        link_clk,
    input  logic        scl_i,
    output logic        scl_o,
    output logic        scl_oe_n,
    input  logic        sda_i,
    output logic        sda_o,
    output logic        sda_oe_n,
    input  logic        alert_i
);

    // =====================================================================
    // Bus domain state.
    tw_pkg::tw_cmd_type cmd_r, cmd_nxt;
    tw_pkg::tw_res_type res;
    logic        en_r, en_nxt;
    logic        busy_r, busy_nxt;
    logic        req_r, req_nxt;
    logic        nak_r, nak_nxt;
    logic        alert_r, alert_nxt;
    logic [31:0] rxd_r, rxd_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic        rd_pend_r, rd_pend_nxt;
    logic [7:0]  bus_addr_r, bus_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        hready_r, hready_nxt;
    logic        hresp_r;
    logic [31:0] rd_word;
    logic        addr_ok;
    logic        go_ok;
    logic [2:0]  nb_req;

    // =====================================================================
    // Crossing flops.
    logic al_s1, al_s2;
    logic dn_s1, dn_s2, dn_d;
    logic done_pls;
    logic done_tgl;
    logic lr_s1, lr_s2;
    logic rq_s1, rq_s2;
    logic ds_s1, ds_s2;
    logic scl_s1, scl_s2;
    logic sda_s1, sda_s2;
    logic pin_lo_r;
    logic seen_r;

    function automatic logic is_wr(input logic pend, input logic [7:0] a,
                                   input logic [7:0] ofs);
        return pend && (a == ofs);
    endfunction : is_wr

    assign addr_ok  = hsel && htrans[1] && hready;
    assign done_pls = dn_s2 ^ dn_d;
    assign nb_req   = hwdata[tw_pkg::CMD_NB_LSB +: 3];
    assign go_ok    = hwdata[tw_pkg::CTRL_GO] && !busy_r
                   && (en_r || hwdata[tw_pkg::CTRL_EN]);

    // =====================================================================
    // AHB-Lite slave: writes take no wait state, reads take one.
    always_comb begin : bus_comb
        wr_pend_nxt  = 1'b0;
        rd_pend_nxt  = 1'b0;
        bus_addr_nxt = bus_addr_r;
        hready_nxt   = 1'b1;
        hrdata_nxt   = hrdata_r;
        if (rd_pend_r) begin
            hrdata_nxt = rd_word;
        end else if (addr_ok) begin
            bus_addr_nxt = haddr[7:0];
            wr_pend_nxt  = hwrite;
            rd_pend_nxt  = !hwrite;
            hready_nxt   = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r  <= 1'b0;
            rd_pend_r  <= 1'b0;
            bus_addr_r <= 8'h00;
            hrdata_r   <= 32'h0;
            hready_r   <= 1'b1;
            hresp_r    <= 1'b0;
        end else begin
            wr_pend_r  <= wr_pend_nxt;
            rd_pend_r  <= rd_pend_nxt;
            bus_addr_r <= bus_addr_nxt;
            hrdata_r   <= hrdata_nxt;
            hready_r   <= hready_nxt;
            hresp_r    <= 1'b0;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp     = hresp_r;

    // =====================================================================
    // Read multiplexer.
    always_comb begin : read_comb
        rd_word = 32'h0;
        case (bus_addr_r)
            tw_pkg::OFS_CTRL:  rd_word[tw_pkg::CTRL_EN] = en_r;
            tw_pkg::OFS_CMD: begin
                rd_word[6:0] = cmd_r.addr;
                rd_word[tw_pkg::CMD_RD] = cmd_r.rd;
                rd_word[tw_pkg::CMD_NB_LSB +: 3] = cmd_r.nbytes;
            end
            tw_pkg::OFS_TXD:   rd_word = cmd_r.txdata;
            tw_pkg::OFS_RXD:   rd_word = rxd_r;
            tw_pkg::OFS_STAT: begin
                rd_word[tw_pkg::STAT_IDLE]  = !busy_r;
                rd_word[tw_pkg::STAT_NAK]   = nak_r;
                rd_word[tw_pkg::STAT_ALERT] = alert_r;
            end
            tw_pkg::OFS_PRESC: rd_word[7:0] = cmd_r.presc;
            default:           rd_word = 32'h0;
        endcase
    end

    // =====================================================================
    // Control and status registers.
    always_comb begin : reg_comb
        en_nxt    = en_r;
        busy_nxt  = busy_r;
        req_nxt   = req_r;
        nak_nxt   = nak_r;
        alert_nxt = alert_r;
        cmd_nxt   = cmd_r;
        rxd_nxt   = rxd_r;
        if (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_CTRL)) begin
            if (hwdata[tw_pkg::CTRL_DIS]) begin
                en_nxt   = 1'b0; // R02
                busy_nxt = 1'b0;
            end else begin
                if (hwdata[tw_pkg::CTRL_EN]) begin
                    en_nxt = 1'b1;
                end
                if (go_ok) begin
                    busy_nxt = 1'b1;
                    req_nxt  = !req_r;
                end
            end
        end
        if (!busy_r) begin
            if (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_CMD)) begin
                cmd_nxt.addr   = hwdata[6:0];
                cmd_nxt.rd     = hwdata[tw_pkg::CMD_RD];
                cmd_nxt.nbytes = (nb_req > tw_pkg::MAX_BYTES) ? tw_pkg::MAX_BYTES : nb_req;
            end
            if (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_TXD)) begin
                cmd_nxt.txdata = hwdata;
            end
            if (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_PRESC)) begin
                cmd_nxt.presc = hwdata[7:0];
            end
        end
        if (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_STAT)) begin
            if (hwdata[tw_pkg::STAT_NAK]) begin
                nak_nxt = 1'b0;
            end
            if (hwdata[tw_pkg::STAT_ALERT]) begin
                alert_nxt = 1'b0;
            end
        end
        if (done_pls && busy_r) begin
            busy_nxt = 1'b0; // R01
            rxd_nxt  = res.rxdata;
            if (res.nak) begin
                nak_nxt = 1'b1;
            end
        end
        if (al_s2) begin
            alert_nxt = 1'b1; // R05
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r          <= tw_pkg::EN_RST;
            busy_r        <= 1'b0;
            req_r         <= 1'b0;
            nak_r         <= 1'b0;
            alert_r       <= tw_pkg::ALERT_RST; // R07
            cmd_r         <= '0;
            cmd_r.presc   <= tw_pkg::PRESC_RST;
            rxd_r         <= 32'h0;
        end else begin
            en_r    <= en_nxt;
            busy_r  <= busy_nxt;
            req_r   <= req_nxt;
            nak_r   <= nak_nxt;
            alert_r <= alert_nxt;
            cmd_r   <= cmd_nxt;
            rxd_r   <= rxd_nxt;
        end
    end

    // =====================================================================
    // Bus domain synchronisers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            al_s1  <= 1'b0;
            al_s2  <= 1'b0;
            dn_s1  <= 1'b0;
            dn_s2  <= 1'b0;
            dn_d   <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            al_s1  <= alert_i;
            al_s2  <= al_s1;
            dn_s1  <= done_tgl;
            dn_s2  <= dn_s1;
            dn_d   <= dn_s2;
            seen_r <= 1'b1;
        end
    end

    // =====================================================================
    // Link domain reset and synchronisers.
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            lr_s1 <= 1'b0;
            lr_s2 <= 1'b0;
        end else begin
            lr_s1 <= 1'b1;
            lr_s2 <= lr_s1;
        end
    end

    always_ff @(posedge link_clk or negedge lr_s2) begin
        if (!lr_s2) begin
            rq_s1    <= 1'b0;
            rq_s2    <= 1'b0;
            ds_s1    <= 1'b1;
            ds_s2    <= 1'b1;
            scl_s1   <= 1'b1;
            scl_s2   <= 1'b1;
            sda_s1   <= 1'b1;
            sda_s2   <= 1'b1;
            pin_lo_r <= 1'b0;
        end else begin
            rq_s1    <= req_r;
            rq_s2    <= rq_s1;
            ds_s1    <= !en_r;
            ds_s2    <= ds_s1;
            scl_s1   <= scl_i;
            scl_s2   <= scl_s1;
            sda_s1   <= sda_i;
            sda_s2   <= sda_s1;
            pin_lo_r <= 1'b0;
        end
    end

    assign scl_o = pin_lo_r;
    assign sda_o = pin_lo_r;

    // =====================================================================
    // Bit engine.
    tw_engine u_engine (
        .link_clk (link_clk),
        .rst_n    (lr_s2),
        .req_lvl  (rq_s2),
        .dis      (ds_s2),
        .cmd      (cmd_r),
        .scl_in   (scl_s2),
        .sda_in   (sda_s2),
        .done_tgl (done_tgl),
        .res      (res),
        .scl_oe_n (scl_oe_n),
        .sda_oe_n (sda_oe_n)
    );

    // =====================================================================
    // Checks.
    sequence s_rd_addr;
        addr_ok && !hwrite;
    endsequence

    a_alert_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R07
        !seen_r |-> alert_r)
        else $error("alert status not set after reset");

    a_alert_high: assert property (@(posedge hclk) disable iff (!hresetn) // R05
        al_s2 |=> alert_r)
        else $error("high alert input not latched");

    a_done_idle: assert property (@(posedge hclk) disable iff (!hresetn) // R01
        (done_pls && busy_r) |=> !busy_r)
        else $error("idle not set on engine done");

    a_dis_idle: assert property (@(posedge hclk) disable iff (!hresetn) // R02
        (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_CTRL) && hwdata[tw_pkg::CTRL_DIS])
        |=> !en_r && !busy_r)
        else $error("disable did not stop the master");

    a_go_request: assert property (@(posedge hclk) disable iff (!hresetn)
        (is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_CTRL) && go_ok
         && !hwdata[tw_pkg::CTRL_DIS]) |=> busy_r && (req_r != $past(req_r)))
        else $error("start did not raise a request");

    a_nak_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (nak_r && !(is_wr(wr_pend_r, bus_addr_r, tw_pkg::OFS_STAT)
         && hwdata[tw_pkg::STAT_NAK])) |=> nak_r)
        else $error("nak flag lost");

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        s_rd_addr |=> !hready_r ##1 hready_r)
        else $error("read answer not after one wait state");

endmodule : tw_master

// *** tw_slave_model.sv ***
// Slave model on the two-wire lines: acks or refuses each byte the master writes and counts STOPs.
// Assumes pulled-up lines; on reads it sends the bytes of rword, byte0 first, MSB first.
`timescale 1ns/1ps
module tw_slave_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nak,
    input  wire logic [31:0] rword,
    output logic      sda_oe_n,
    output int        stops
);
    // =====================================================================
    // Bit count from START, ack or refusal as the ninth bit of each byte the master writes.
    int bits;
    int p;
    logic rd;
    initial begin
        sda_oe_n = 1'b1;
        stops = 0;
        bits = 0;
        rd = 1'b0;
    end
    always @(negedge sda) if (scl) bits = 0;
    always @(posedge sda) if (scl) stops = stops + 1;
    always @(posedge scl) begin
        bits = bits + 1;
        if (bits == 8) rd = sda;
    end
    always @(negedge scl) begin
        p = bits - 9;
        if (rd && bits > 8)
            sda_oe_n = (p % 9 == 8) || rword[8 * (p / 9) + 7 - p % 9];
        else
            sda_oe_n = !(bits % 9 == 8 && !nak);
    end
endmodule : tw_slave_model

// *** tw_master_bench.sv ***
// Bench of the two-wire master: registers, NAK, disable and alert cases.
// Assumes the slave model on the lines and a fixed random seed.
`timescale 1ns/1ps
module tw_master_bench;
    logic        hclk = 1'b0;
    logic        link_clk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        alert_i = 1'b0;
    logic        nak = 1'b0;
    logic [31:0] rword = 32'h0;
    logic [2:0]  rnb;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n, s_oe_n;
    wire         scl = scl_oe_n | scl_o;
    wire         sda = (sda_oe_n | sda_o) & s_oe_n;
    int          stops, s0, bad_count = 0, total_checks = 0;

    always #25 hclk = ~hclk;
    always #24 link_clk = ~link_clk;

    tw_master tw_master_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_i(alert_i));
    tw_slave_model tw_slave_model_i (.scl(scl), .sda(sda), .nak(nak), .rword(rword),
        .sda_oe_n(s_oe_n), .stops(stops));

    // =====================================================================
    // Shared tasks.
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    function automatic logic [31:0] rx_exp(input logic [31:0] w, input logic [2:0] nb);
        return w & ~(32'hffffffff << (8 * nb));
    endfunction : rx_exp

    task automatic go(input logic rd, input logic [2:0] nb);
        bus(1'b1, tw_pkg::OFS_CMD, {21'h0, nb, rd, 7'($urandom)});
        bus(1'b1, tw_pkg::OFS_TXD, $urandom);
        bus(1'b1, tw_pkg::OFS_CTRL, 32'h5);
        s0 = stops;
        repeat (4) @(posedge hclk);
    endtask : go

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, tw_pkg::OFS_STAT, 32'h0);
            n++;
        end while (q[0] !== 1'b1 && n < 1000);
    endtask : wait_idle

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    initial begin
        #1000000;
        bad_count++;
        results();
    end

    // =====================================================================
    // Main sequence.
    initial begin
        void'($urandom(50));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, tw_pkg::OFS_STAT, 32'h0);
        chk(32'h5, q);
        bus(1'b0, tw_pkg::OFS_CTRL, 32'h0);
        chk(32'h0, q);
        bus(1'b0, 8'h18, 32'h0);
        chk(32'h0, q);
        bus(1'b1, tw_pkg::OFS_STAT, 32'h4);
        bus(1'b0, tw_pkg::OFS_STAT, 32'h0);
        chk(32'h1, q);
        alert_i <= 1'b1;
        repeat (1 + $urandom % 3) @(posedge hclk);
        alert_i <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b0, tw_pkg::OFS_STAT, 32'h0);
        chk(32'h5, q);
        bus(1'b1, tw_pkg::OFS_STAT, 32'h4);
        bus(1'b1, tw_pkg::OFS_PRESC, 32'h3);
        nak <= 1'b1;
        go(1'b0, 3'h2);
        wait_idle;
        chk(32'h3, q);
        chk(s0, stops);
        repeat (100) @(posedge hclk);
        chk(s0 + 1, stops);
        chk(32'h1, {31'h0, scl & sda});
        bus(1'b1, tw_pkg::OFS_STAT, 32'h2);
        nak <= 1'b0;
        rword <= $urandom;
        rnb = 3'(1 + $urandom % 4);
        go(1'b1, rnb);
        wait_idle;
        chk(32'h1, q);
        bus(1'b0, tw_pkg::OFS_RXD, 32'h0);
        chk(rx_exp(rword, rnb), q);
        go(1'b0, 3'h4);
        repeat (36) @(posedge hclk);
        bus(1'b1, tw_pkg::OFS_CTRL, 32'h2);
        repeat (6) @(posedge hclk);
        chk(32'h3, {30'h0, scl_oe_n, sda_oe_n});
        bus(1'b0, tw_pkg::OFS_CTRL, 32'h0);
        chk(32'h0, q);
        results();
    end
endmodule : tw_master_bench
